// ===== hdl/dsr_regs.sv
// Receiver control and status registers of the link deserializer.
// Assumes register requests arrive on the register clock from the
// serial control slave; strap and gpio pins are asynchronous.
module dsr_regs (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Register access
  input wire dsr_pkg::dsr_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Link state
  input wire logic linked_i,
  input wire logic video_off_i,
  output logic rx_lock_o,
  output logic video_off_o,
  // Receive mode
  output dsr_pkg::dsr_in_mode_t input_mode_o,
  // Back channel gpio
  input wire logic first_data_gpio_i,
  output logic backchannel_gpio_o,
  // Equalizer controls
  output dsr_pkg::dsr_eq_t eq_ctl_o,
  // Mode strap pins, already level decoded
  input wire logic [2:0] first_strap_level_i,
  input wire logic [2:0] second_strap_level_i,
  // Audio clock divider
  input wire logic [2:0] auto_vco_divide_i,
  output logic [2:0] vco_divide_o,
  output logic [2:0] vco_input_divide_o,
  output logic vco_input_override_o,
  // Per port configuration
  output logic [7:0] port0_cfg_o,
  output logic [7:0] port1_cfg_o
);

  import dsr_pkg::*;

  // Register storage
  logic [7:0] dual_rx_ff;
  logic [7:0] eq_ctl1_ff;
  logic [7:0] divsel_ff;
  logic [7:0] eq_ctl2_ff;
  logic [7:0] port_cfg_ff [2];
  logic [2:0] first_strap_ff;
  logic [2:0] second_strap_ff;
  logic first_done_ff;
  logic second_done_ff;
  logic [DSR_STRAP_CNT_W-1:0] strap_cnt_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic rx_lock_ff;
  logic video_off_ff;
  logic [2:0] gpio_hist_ff;
  logic backchannel_ff;
  dsr_eq_t eq_ff;
  logic [2:0] vco_div_ff;
  dsr_in_mode_t in_mode_ff;

  // Synchronised pins
  logic [2:0] first_strap_s;
  logic [2:0] second_strap_s;
  logic gpio_s;

  // Pin synchronisers
  dsr_sync #(.WIDTH(3)) u_sync_strap0 (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .async_i(first_strap_level_i),
    .sync_o(first_strap_s)
  );

  dsr_sync #(.WIDTH(3)) u_sync_strap1 (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .async_i(second_strap_level_i),
    .sync_o(second_strap_s)
  );

  dsr_sync #(.WIDTH(1)) u_sync_gpio (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .async_i(first_data_gpio_i),
    .sync_o(gpio_s)
  );

  // Address decode
  wire hit_dual_rx = reg_req_i.addr == DSR_ADDR_DUAL_RX;
  wire hit_eq_ctl1 = reg_req_i.addr == DSR_ADDR_EQ_CTL1;
  wire hit_strap = reg_req_i.addr == DSR_ADDR_STRAP;
  wire hit_divsel = reg_req_i.addr == DSR_ADDR_DIVSEL;
  wire hit_eq_ctl2 = reg_req_i.addr == DSR_ADDR_EQ_CTL2;
  wire hit_port = reg_req_i.addr == DSR_ADDR_PORT_CFG;

  // Port selection for per-port registers
  wire sel_port0 = dual_rx_ff[DSR_FIRST_PORT_SELECT_BIT];
  wire sel_port1 = dual_rx_ff[DSR_SECOND_PORT_SELECT_BIT];
  wire wr_port0 = reg_req_i.wr && hit_port && sel_port0;
  wire wr_port1 = reg_req_i.wr && hit_port && sel_port1;
  // Second port wins a read when both are selected
  wire [7:0] port_rd_val = sel_port1 ? port_cfg_ff[1] :
                           sel_port0 ? port_cfg_ff[0] : 8'h00;

  // Masked write data, reserved bits stay zero
  wire [7:0] nxt_dual_rx = reg_req_i.wdata & DSR_WMASK_DUAL_RX;
  wire [7:0] nxt_eq_ctl1 = reg_req_i.wdata & DSR_WMASK_EQ_CTL1;
  wire [7:0] nxt_divsel = reg_req_i.wdata & DSR_WMASK_DIVSEL;
  wire [7:0] nxt_eq_ctl2 = reg_req_i.wdata & DSR_WMASK_EQ_CTL2;

  // Strap status view
  wire [7:0] strap_view = {second_done_ff, second_strap_ff,
                           first_done_ff, first_strap_ff};

  // Read data mux, unmapped reads return zero
  wire [7:0] nxt_rdata =
    hit_dual_rx ? dual_rx_ff :
    hit_eq_ctl1 ? eq_ctl1_ff :
    hit_strap ? strap_view :
    hit_divsel ? divsel_ff :
    hit_eq_ctl2 ? eq_ctl2_ff :
    hit_port ? port_rd_val : 8'h00;

  // Lock indication per lock mode
  wire nxt_rx_lock = dual_rx_ff[DSR_LOCK_MODE_BIT] ?
                     linked_i :
                     (linked_i && !video_off_i);

  // Majority of three samples filters glitches on the gpio
  wire gpio_major = (gpio_hist_ff[0] & gpio_hist_ff[1]) |
                    (gpio_hist_ff[1] & gpio_hist_ff[2]) |
                    (gpio_hist_ff[0] & gpio_hist_ff[2]);
  wire nxt_backchannel = dual_rx_ff[DSR_RAW_BC_BIT] ?
                         gpio_s : gpio_major;

  // Receive input mode decode
  wire [1:0] in_mode_code = dual_rx_ff[DSR_IN_MODE_MSB:DSR_IN_MODE_LSB];
  wire dsr_in_mode_t nxt_in_mode = dsr_in_mode_t'(in_mode_code);

  // Equalizer controls, floor apply gated by override
  wire dsr_eq_t nxt_eq = '{
    restart: eq_ctl1_ff[DSR_EQ_RESTART_BIT],
    floor_en: eq_ctl1_ff[DSR_EQ_FLOOR_OV_BIT] &&
              eq_ctl1_ff[DSR_EQ_FLOOR_SET_BIT],
    floor_value: eq_ctl2_ff[DSR_EQ_FLOOR_MSB:0]
  };

  // Divider source select
  wire [2:0] nxt_vco_div = divsel_ff[DSR_DIV_OV_BIT] ?
                           divsel_ff[DSR_VCO_DIV_MSB:DSR_VCO_DIV_LSB] :
                           auto_vco_divide_i;

  // Strap settle counter end
  wire strap_settled =
    strap_cnt_ff == DSR_STRAP_CNT_W'(DSR_STRAP_CYCLES - 1);

  // Shared control registers, hold until software rewrites
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dual_rx_ff <= DSR_RST_DUAL_RX;
      eq_ctl1_ff <= DSR_RST_EQ_CTL1;
      divsel_ff <= DSR_RST_DIVSEL;
      eq_ctl2_ff <= DSR_RST_EQ_CTL2;
    end
    else
    begin
      if (reg_req_i.wr && hit_dual_rx)
        dual_rx_ff <= nxt_dual_rx;
      if (reg_req_i.wr && hit_eq_ctl1)
        eq_ctl1_ff <= nxt_eq_ctl1;
      if (reg_req_i.wr && hit_divsel)
        divsel_ff <= nxt_divsel;
      if (reg_req_i.wr && hit_eq_ctl2)
        eq_ctl2_ff <= nxt_eq_ctl2;
    end
  end

  // Per-port registers, written for every selected port
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      port_cfg_ff[0] <= DSR_RST_PORT_CFG;
      port_cfg_ff[1] <= DSR_RST_PORT_CFG;
    end
    else
    begin
      if (wr_port0)
        port_cfg_ff[0] <= reg_req_i.wdata;
      if (wr_port1)
        port_cfg_ff[1] <= reg_req_i.wdata;
    end
  end

  // Strap decode latched once after settle time
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      strap_cnt_ff <= '0;
      first_strap_ff <= 3'h0;
      second_strap_ff <= 3'h0;
      first_done_ff <= 1'b0;
      second_done_ff <= 1'b0;
    end
    else if (!first_done_ff)
    begin
      if (strap_settled)
      begin
        first_strap_ff <= first_strap_s;
        second_strap_ff <= second_strap_s;
        first_done_ff <= 1'b1;
        second_done_ff <= 1'b1;
      end
      else
        strap_cnt_ff <= strap_cnt_ff + 1'b1;
    end
  end

  // Read answer, one cycle after the request
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= reg_req_i.rd;
      if (reg_req_i.rd)
        rdata_ff <= nxt_rdata;
    end
  end

  // Link status and back channel outputs
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rx_lock_ff <= 1'b0;
      video_off_ff <= 1'b0;
      gpio_hist_ff <= 3'h0;
      backchannel_ff <= 1'b0;
    end
    else
    begin
      rx_lock_ff <= nxt_rx_lock;
      video_off_ff <= video_off_i;
      gpio_hist_ff <= {gpio_hist_ff[1:0], gpio_s};
      backchannel_ff <= nxt_backchannel;
    end
  end

  // Mode, equalizer and divider outputs
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      in_mode_ff <= DSR_IN_AUTO;
      eq_ff <= '0;
      vco_div_ff <= 3'h0;
    end
    else
    begin
      in_mode_ff <= nxt_in_mode;
      eq_ff <= nxt_eq;
      vco_div_ff <= nxt_vco_div;
    end
  end

  // Output assignments
  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign rx_lock_o = rx_lock_ff;
  assign video_off_o = video_off_ff;
  assign input_mode_o = in_mode_ff;
  assign backchannel_gpio_o = backchannel_ff;
  assign eq_ctl_o = eq_ff;
  assign vco_divide_o = vco_div_ff;
  assign vco_input_divide_o = divsel_ff[1:0] == 2'h0 ? 3'h0 :
                              {1'b0, divsel_ff[1:0]};
  assign vco_input_override_o = divsel_ff[2];
  assign port0_cfg_o = port_cfg_ff[0];
  assign port1_cfg_o = port_cfg_ff[1];

endmodule : dsr_regs

// ===== hdl/dsr_pkg.sv
// Package for the receiver control register block.
// Assumes one 20 MHz register clock and an active-low asynchronous reset.
package dsr_pkg;

  // Register offsets
  localparam logic [7:0] DSR_ADDR_DUAL_RX = 8'h34;
  localparam logic [7:0] DSR_ADDR_EQ_CTL1 = 8'h35;
  localparam logic [7:0] DSR_ADDR_STRAP = 8'h37;
  localparam logic [7:0] DSR_ADDR_DIVSEL = 8'h3a;
  localparam logic [7:0] DSR_ADDR_EQ_CTL2 = 8'h45;
  localparam logic [7:0] DSR_ADDR_PORT_CFG = 8'h4f;

  // Reset values
  localparam logic [7:0] DSR_RST_DUAL_RX = 8'h01;
  localparam logic [7:0] DSR_RST_EQ_CTL1 = 8'h00;
  localparam logic [7:0] DSR_RST_DIVSEL = 8'h00;
  localparam logic [7:0] DSR_RST_EQ_CTL2 = 8'h00;
  localparam logic [7:0] DSR_RST_PORT_CFG = 8'h00;

  // Writable bit masks, reserved bits stay zero
  localparam logic [7:0] DSR_WMASK_DUAL_RX = 8'h7b;
  localparam logic [7:0] DSR_WMASK_EQ_CTL1 = 8'h70;
  localparam logic [7:0] DSR_WMASK_DIVSEL = 8'hf7;
  localparam logic [7:0] DSR_WMASK_EQ_CTL2 = 8'h3f;

  // Field positions, dual receive control
  localparam int DSR_LOCK_MODE_BIT = 6;
  localparam int DSR_RAW_BC_BIT = 5;
  localparam int DSR_IN_MODE_MSB = 4;
  localparam int DSR_IN_MODE_LSB = 3;
  localparam int DSR_SECOND_PORT_SELECT_BIT = 1;
  localparam int DSR_FIRST_PORT_SELECT_BIT = 0;

  // Field positions, equalizer controls one and two
  localparam int DSR_EQ_RESTART_BIT = 6;
  localparam int DSR_EQ_FLOOR_OV_BIT = 5;
  localparam int DSR_EQ_FLOOR_SET_BIT = 4;
  localparam int DSR_EQ_FLOOR_MSB = 5;

  // Field positions, divider select
  localparam int DSR_DIV_OV_BIT = 7;
  localparam int DSR_VCO_DIV_MSB = 6;
  localparam int DSR_VCO_DIV_LSB = 4;

  // Strap settle time and its cycle count at 20 MHz
  localparam int DSR_CLK_PERIOD_NS = 50;
  localparam int DSR_STRAP_SETTLE_NS = 1000;
  localparam int DSR_STRAP_CYCLES =
    (DSR_STRAP_SETTLE_NS + DSR_CLK_PERIOD_NS - 1) / DSR_CLK_PERIOD_NS;
  localparam int DSR_STRAP_CNT_W = 6;

  // Receive input modes
  typedef enum logic [1:0] {
    DSR_IN_AUTO,
    DSR_IN_DUAL,
    DSR_IN_SINGLE_PRI,
    DSR_IN_SINGLE_SEC
  } dsr_in_mode_t;

  // Register access request from the serial control slave
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dsr_req_t;

  // Equalizer controls toward both receive ports
  typedef struct packed {
    logic restart;
    logic floor_en;
    logic [5:0] floor_value;
  } dsr_eq_t;

endpackage : dsr_pkg

// ===== hdl/dsr_sync.sv
// Two-stage synchroniser for asynchronous pin inputs.
// Assumes the destination clock is the register clock.
module dsr_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage feeds only the second
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule : dsr_sync

// ===== bench/dsr_regs_monitor.sv
// Checker for the receiver control registers.
// Assumes strap pins stay fixed from reset onward.
module dsr_regs_monitor (
  // Clock, reset and register bus
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire dsr_pkg::dsr_req_t reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  // Link, gpio and derived controls
  input wire logic linked_i,
  input wire logic video_off_i,
  input wire logic rx_lock_o,
  input wire dsr_pkg::dsr_in_mode_t input_mode_o,
  input wire logic first_data_gpio_i,
  input wire logic backchannel_gpio_o,
  input wire dsr_pkg::dsr_eq_t eq_ctl_o,
  input wire logic [2:0] auto_vco_divide_i,
  input wire logic [2:0] vco_divide_o,
  input wire logic [7:0] port0_cfg_o,
  input wire logic [7:0] port1_cfg_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import dsr_pkg::*;
  logic [7:0] dual_ff, eq_ff, div_ff;
  logic [4:0] age_ff;
  // Request decode
  wire logic [7:0] ra = reg_req_i.addr;
  wire logic own_rd = reg_req_i.rd && (ra == DSR_ADDR_DUAL_RX ||
    ra == DSR_ADDR_EQ_CTL1 || ra == DSR_ADDR_DIVSEL);
  wire logic [7:0] own_exp = ra == DSR_ADDR_EQ_CTL1 ? eq_ff :
    ra == DSR_ADDR_DIVSEL ? div_ff : dual_ff;
  wire logic [7:0] port_exp = dual_ff[1] ? port1_cfg_o :
    dual_ff[0] ? port0_cfg_o : 8'h00;
  // Shadow registers and cycles since reset
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dual_ff <= DSR_RST_DUAL_RX;
      eq_ff <= 8'h00;
      div_ff <= 8'h00;
      age_ff <= 5'h00;
    end
    else
    begin
      if (age_ff != 5'h1f)
        age_ff <= age_ff + 5'h01;
      if (reg_req_i.wr && ra == DSR_ADDR_DUAL_RX)
        dual_ff <= reg_req_i.wdata & DSR_WMASK_DUAL_RX;
      if (reg_req_i.wr && ra == DSR_ADDR_EQ_CTL1)
        eq_ff <= reg_req_i.wdata & DSR_WMASK_EQ_CTL1;
      if (reg_req_i.wr && ra == DSR_ADDR_DIVSEL)
        div_ff <= reg_req_i.wdata & DSR_WMASK_DIVSEL;
    end
  end
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  a_lock_video_only: assert property (
    !dual_ff[6] |=> rx_lock_o == $past(linked_i && !video_off_i))
    else $error("lock not tied to video");
  a_lock_when_linked: assert property (
    dual_ff[6] |=> rx_lock_o == $past(linked_i))
    else $error("lock not tied to link");
  a_raw_gpio_pass: assert property (
    dual_ff[5] [*4] |-> backchannel_gpio_o == $past(first_data_gpio_i, 3))
    else $error("raw gpio not passed");
  a_input_mode_out: assert property (
    1'b1 |=> input_mode_o == $past(dual_ff[4:3]))
    else $error("input mode wrong");
  a_port1_write: assert property (
    reg_req_i.wr && ra == DSR_ADDR_PORT_CFG && dual_ff[1]
    |=> port1_cfg_o == $past(reg_req_i.wdata))
    else $error("port1 not written");
  a_port_read_sel: assert property (
    reg_req_i.rd && ra == DSR_ADDR_PORT_CFG |=> reg_rdata_o == $past(port_exp))
    else $error("port read wrong");
  a_restart_level: assert property (
    1'b1 |=> eq_ctl_o.restart == $past(eq_ff[6]))
    else $error("restart wrong");
  a_floor_gated: assert property (
    1'b1 |=> eq_ctl_o.floor_en == $past(eq_ff[5] && eq_ff[4]))
    else $error("floor gate wrong");
  a_divider_source: assert property (
    1'b1 |=> vco_divide_o == ($past(div_ff[7]) ? $past(div_ff[6:4]) :
    $past(auto_vco_divide_i)))
    else $error("divider wrong");
  a_strap_not_done: assert property (
    reg_req_i.rd && ra == DSR_ADDR_STRAP && age_ff < 5'h10
    |=> reg_rdata_o == 8'h00)
    else $error("strap done too early");
  a_readback_masked: assert property (
    own_rd |=> reg_rdata_o == $past(own_exp))
    else $error("readback wrong");
  c_lock_no_video: cover property (dual_ff[6] && rx_lock_o && video_off_i);
  c_raw_pulse: cover property (dual_ff[5] && $rose(backchannel_gpio_o));
  c_both_ports: cover property (dual_ff[1:0] == 2'h3 && reg_req_i.rd);
endmodule : dsr_regs_monitor

bind dsr_regs dsr_regs_monitor dsr_regs_monitor_inst (.clock_i, .resetn_i,
  .reg_req_i, .reg_rdata_o, .linked_i, .video_off_i, .rx_lock_o,
  .input_mode_o, .first_data_gpio_i, .backchannel_gpio_o, .eq_ctl_o,
  .auto_vco_divide_i, .vco_divide_o, .port0_cfg_o, .port1_cfg_o);

// ===== bench/dsr_ser_model.sv
// Model of the remote serializer's link state.
// Assumes the bench commands link and video between clock edges.
module dsr_ser_model (
  // Clock and commands
  input wire logic clock_i,
  input wire logic link_up_i,
  input wire logic video_on_i,
  // Link state toward the receiver
  output logic linked_o,
  output logic video_off_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle link with no video
  initial
  begin
    linked_o = 1'b0;
    video_off_o = 1'b1;
  end
  // State changes just after an edge
  always @(posedge clock_i)
  begin
    linked_o <= #5 link_up_i;
    video_off_o <= #5 !(link_up_i && video_on_i);
  end
endmodule : dsr_ser_model

// ===== bench/tb_top.sv
// Self-checking bench for the receiver control registers.
// Assumes the serializer model and the bound checker.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dsr_pkg::*;
  logic clock_i, resetn_i, link_up, video_on, linked, video_off;
  logic rvalid, rx_lock, vid_off, gpio, bc_gpio;
  logic [7:0] rdata, p0_cfg, p1_cfg;
  logic [2:0] auto_div, vco_div, in_div;
  logic in_ov;
  dsr_req_t reg_req;
  dsr_in_mode_t in_mode;
  dsr_eq_t eq_ctl;
  int num_errors = 0;
  int checks_done = 0;
  dsr_regs dsr_regs_inst (.clock_i, .resetn_i, .reg_req_i(reg_req),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .linked_i(linked),
    .video_off_i(video_off), .rx_lock_o(rx_lock), .video_off_o(vid_off),
    .input_mode_o(in_mode), .first_data_gpio_i(gpio),
    .backchannel_gpio_o(bc_gpio), .eq_ctl_o(eq_ctl),
    .first_strap_level_i(3'h5), .second_strap_level_i(3'h2),
    .auto_vco_divide_i(auto_div), .vco_divide_o(vco_div),
    .vco_input_divide_o(in_div), .vco_input_override_o(in_ov),
    .port0_cfg_o(p0_cfg), .port1_cfg_o(p1_cfg));
  dsr_ser_model dsr_ser_model_inst (.clock_i, .link_up_i(link_up),
    .video_on_i(video_on), .linked_o(linked), .video_off_o(video_off));
  // Clock
  initial
  begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic check(input string what, input logic [7:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #5;
  endtask : tick
  task automatic reg_wr(input logic [7:0] a, d);
    @(posedge clock_i);
    #5 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick(1);
    reg_req = '0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, e, input string what);
    @(posedge clock_i);
    #5 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    tick(1);
    reg_req = '0;
    check("rvalid", 8'h01, {7'h00, rvalid});
    check(what, e, rdata);
  endtask : reg_rd
  task automatic t_reset();
    reg_rd(DSR_ADDR_STRAP, 8'h00, "strap early");
    reg_rd(DSR_ADDR_DUAL_RX, 8'h01, "dual reset");
    reg_rd(DSR_ADDR_EQ_CTL1, 8'h00, "eq reset");
    reg_rd(DSR_ADDR_DIVSEL, 8'h00, "div reset");
    tick(24);
    check("rvalid low", 8'h00, {7'h00, rvalid});
    reg_wr(DSR_ADDR_STRAP, 8'h00);
    reg_rd(DSR_ADDR_STRAP, 8'had, "strap");
    $display("test reset done");
  endtask : t_reset
  task automatic t_lock();
    for (int i = 0; i < 8; i++)
    begin
      reg_wr(DSR_ADDR_DUAL_RX, {1'b0, i[2], 6'h01});
      link_up = i[1];
      video_on = i[0];
      tick(3);
      check("video off", {7'h00, !(i[1] && i[0])}, {7'h00, vid_off});
      check("lock", {7'h00, i[1] && (i[2] || i[0])}, {7'h00, rx_lock});
    end
    $display("test lock done");
  endtask : t_lock
  task automatic t_modes();
    for (int m = 0; m < 4; m++)
    begin
      reg_wr(DSR_ADDR_DUAL_RX, {3'h0, m[1:0], 3'h1});
      tick(1);
      check("input mode", {6'h00, m[1:0]}, {6'h00, in_mode});
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_ports();
    reg_wr(DSR_ADDR_DUAL_RX, 8'h03);
    reg_wr(DSR_ADDR_PORT_CFG, 8'ha5);
    reg_wr(DSR_ADDR_DUAL_RX, 8'h01);
    reg_wr(DSR_ADDR_PORT_CFG, 8'h3c);
    reg_rd(DSR_ADDR_PORT_CFG, 8'h3c, "port0");
    reg_wr(DSR_ADDR_DUAL_RX, 8'h02);
    reg_rd(DSR_ADDR_PORT_CFG, 8'ha5, "port1");
    reg_wr(DSR_ADDR_DUAL_RX, 8'h03);
    reg_rd(DSR_ADDR_PORT_CFG, 8'ha5, "both");
    check("port0 out", 8'h3c, p0_cfg);
    check("port1 out", 8'ha5, p1_cfg);
    $display("test ports done");
  endtask : t_ports
  task automatic t_eq();
    reg_wr(DSR_ADDR_EQ_CTL2, 8'hff);
    reg_wr(DSR_ADDR_EQ_CTL1, 8'hff);
    tick(1);
    check("eq on", 8'hff, eq_ctl);
    reg_rd(DSR_ADDR_EQ_CTL1, 8'h70, "eq mask");
    reg_wr(DSR_ADDR_EQ_CTL1, 8'h50);
    tick(1);
    check("eq gated", 8'h02, {6'h00, eq_ctl[7:6]});
    reg_wr(DSR_ADDR_EQ_CTL1, 8'h00);
    tick(1);
    check("eq off", 8'h00, {6'h00, eq_ctl[7:6]});
    $display("test eq done");
  endtask : t_eq
  task automatic t_div();
    auto_div = 3'h5;
    reg_wr(DSR_ADDR_DIVSEL, 8'hff);
    tick(1);
    check("div reg", 8'h07, {5'h00, vco_div});
    check("vco in div", 8'h0b, {4'h0, in_ov, in_div});
    reg_rd(DSR_ADDR_DIVSEL, 8'hf7, "div mask");
    reg_wr(DSR_ADDR_DIVSEL, 8'h80);
    tick(1);
    check("div code 0", 8'h00, {5'h00, vco_div});
    reg_wr(DSR_ADDR_DIVSEL, 8'h00);
    tick(1);
    check("div auto", 8'h05, {5'h00, vco_div});
    $display("test div done");
  endtask : t_div
  task automatic t_raw();
    for (int r = 1; r >= 0; r--)
    begin
      reg_wr(DSR_ADDR_DUAL_RX, {2'h0, r[0], 5'h01});
      tick(4);
      gpio = 1'b1;
      tick(1);
      gpio = 1'b0;
      tick(2);
      check("gpio pulse", {7'h00, r[0]}, {7'h00, bc_gpio});
    end
    gpio = 1'b1;
    tick(6);
    check("gpio level", 8'h01, {7'h00, bc_gpio});
    gpio = 1'b0;
    $display("test raw done");
  endtask : t_raw
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // Main sequence
  initial
  begin
    reg_req = '0;
    resetn_i = 1'b0;
    link_up = 1'b0;
    video_on = 1'b0;
    gpio = 1'b0;
    auto_div = 3'h0;
    repeat (16) @(posedge clock_i);
    #5 resetn_i = 1'b1;
    t_reset();
    t_lock();
    t_modes();
    t_ports();
    t_eq();
    t_div();
    t_raw();
    wrap_up();
  end
endmodule : tb_top
